// [rtl/apdc_top.sv]
// Top: automatic powerdown control for a line transceiver
//
// Notes on behaviour
// R1: Thirty idle seconds power down pump, drivers
// R2: Any transmit or receive input transition wakes automatic powerdown
// R3: Auto powerdown only when force-active low, shutdown high
// R4: Force-active high disables inactivity powerdown
// R5: Force-shutdown low forces manual powerdown always
// R6: Timer stays expired while down until wake
// R7: No-signal flag low after 60us all invalid
// R8: No-signal flag never changes power state
// R9: Flag returns high 1us after valid level
// R10: No-signal detection works in every mode
// R11: Full operation about 25us after wake
// R12: Outside wiring of flag to both forces
// R13: Flag on shutdown input holds down until transition
// R14: Transmitters high impedance in any powerdown
// R15: Inverting receivers off only in manual powerdown
// R16: Monitor receiver output always active
// R17: Force-active falling edge restarts thirty second timer
// R18: Timeouts are counters of the system clock
// R19: Receivers supply valid levels and samples
`timescale 1ns/1ps
module apdc_top
    import apdc_pkg::*;
#(
    parameter int        N_TX        = 5,
    parameter int        N_RX        = 4,
    parameter int        IDLE_CNT    = int'(IDLE_CYCLES),
    parameter int        INVALID_CNT = int'(INVALID_CYCLES),
    parameter int        VALID_CNT   = int'(VALID_CYCLES),
    parameter int        WAKE_CNT    = int'(WAKE_CYCLES)
) (
    // Clock and reset
    input  wire logic            REF_CLK,
    input  wire logic            RST,
    // Force controls from host pins
    input  wire logic            FORCE_ACTIVE_INPUT,
    input  wire logic            FORCE_SHUTDOWN_INPUT,
    // Line activity inputs
    input  wire logic [N_TX-1:0] TX_IN,
    input  wire logic [N_RX-1:0] RX_IN,
    input  wire logic [N_RX-1:0] RX_LEVEL_VALID,
    // Power and output controls
    output logic                 PUMP_EN,
    output logic                 TX_OE,
    output logic                 RX_OE,
    output logic                 MONITOR_RECEIVER_OE,
    output logic                 READY,
    output logic                 NO_SIGNAL_N,
    output logic [3:0]           MODE
);
    import apdc_pkg::*;

    // Bundle order, high to low: force-active, shutdown, valid flags, receive, transmit
    localparam int NS = N_TX + 2 * N_RX + 2;   // Synchronised pin count

    // Idle level of every pin: shutdown high, everything else low.
    // The whole chain resets to it, so the release of reset shows no false edge.
    localparam logic [NS-1:0] PIN_IDLE = {2'b01, {(NS-2){1'b0}}};

    // Pin bundle through three stages; change counts once stages two and three agree
    wire  [NS-1:0] pins_in = {FORCE_ACTIVE_INPUT, FORCE_SHUTDOWN_INPUT,
                              RX_LEVEL_VALID, RX_IN, TX_IN};
    logic [NS-1:0] s1, s2, s3;                 // Sync chain
    logic [NS-1:0] clean;                      // Accepted level
    logic [NS-1:0] clean_d;                    // Previous accepted level
    // Stages agree: take stage three, else hold; a lone disagreement never
    // reaches the control logic
    wire  [NS-1:0] agree      = s2 ~^ s3;                      // Stages two and three match
    wire  [NS-1:0] next_clean = (agree & s3) | (~agree & clean); // Filtered level
    // Cost: four cycles of latency on every pin, nothing against the timeouts

    // Synchroniser and filter; only stage two reads stage one
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            // Chain starts at the idle pattern
            s1      <= PIN_IDLE;
            s2      <= PIN_IDLE;
            s3      <= PIN_IDLE;
            clean   <= PIN_IDLE;
            clean_d <= PIN_IDLE;
        end else begin
            s1      <= pins_in;
            s2      <= s1;
            s3      <= s2;
            clean   <= next_clean;
            clean_d <= clean;
        end
    end

    // Decoded controls and activity
    wire [N_TX-1:0] tx_s     = clean[N_TX-1:0];
    wire [N_RX-1:0] rx_s     = clean[N_TX +: N_RX];
    wire [N_RX-1:0] rxv_s    = clean[N_TX+N_RX +: N_RX];
    wire            fsd      = clean[NS-2];
    wire            fact     = clean[NS-1];
    wire            fact_d   = clean_d[NS-1];
    // Edges of accepted levels; transmit and receive samples count as activity,
    // valid-level flags do not
    wire [NS-1:0]   edges    = clean ^ clean_d;
    wire            activity = |edges[N_TX+N_RX-1:0];     // R19
    // Either edge of force-active restarts the idle timer
    wire            fact_rise = fact & ~fact_d;
    wire            fact_fall = ~fact & fact_d;
    // Shutdown low dominates; force-active only matters while shutdown is high
    wire            auto_en  = ~fact & fsd;               // R3
    wire            man_pd   = ~fsd;                      // R5

    // No-signal detector; runs in every mode, and its flag only reaches the pin
    // Limitation: the flag lags the lines by the pin filter as well
    apdc_if nsig ();
    apdc_nosig #(
        .N_RX        (N_RX),
        .INVALID_CNT (INVALID_CNT),
        .VALID_CNT   (VALID_CNT)
    ) u_nosig (
        .clk      (REF_CLK),
        .rst      (RST),
        .rx_valid (rxv_s),
        .res      (nsig.det)
    );

    // Inactivity timer; expired stays set while down
    // Thirty seconds at 10 MHz fit in 32 bits; a much faster clock needs IDLE_W raised
    // Limitation: a pin that toggles faster than the filter settles counts no edge
    logic [IDLE_W-1:0] idle_cnt;              // Cycles since last activity
    logic              expired;               // Timer timed out
    wire               restart = activity | fact_fall | fact_rise; // R17
    wire               hit     = idle_cnt == IDLE_W'(IDLE_CNT - 1);
    // Expiry as the mode logic sees it: a restart in this very cycle already
    // counts, so a force-active fall or a wake edge is never one cycle late
    wire               timed_out = expired & ~restart;    // R2 R17

    // Timer process: a restart beats everything, manual powerdown pins the timer
    // expired, and the count freezes once expired so it never wraps to zero.
    // A restart in manual powerdown is re-expired on the very next cycle.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            idle_cnt <= '0;
            expired  <= 1'b0;
        end else if (restart) begin
            idle_cnt <= '0;                   // R2
            expired  <= 1'b0;
        end else if (man_pd) begin
            expired  <= 1'b1;                 // R6
        end else if (!expired && hit) begin
            expired  <= 1'b1;                 // R1 R18
        end else if (!expired) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // Mode selection: flag state never enters here
    // MODE mirrors this register one for one, so outside logic sees the state
    apdc_mode_t mode, next_mode;              // R8
    logic [SHORT_W-1:0] wake_cnt;             // Recovery time counter
    // Down request: manual always, automatic only with the timer expired
    wire want_down = man_pd | (auto_en & timed_out); // R4 R13
    wire wake_done = wake_cnt == SHORT_W'(WAKE_CNT - 1); // Recovery time spent

    // Next mode; leaving either powerdown goes through the recovery wait
    always_comb begin
        next_mode = mode;
        unique case (mode)
            // Full operation until a down request
            APDC_ACTIVE:  if (man_pd) next_mode = APDC_MAN_PD;
                          else if (auto_en && timed_out) next_mode = APDC_AUTO_PD;
            // Pump up, drivers still off; a down request aborts the wait
            APDC_WAKING:  if (want_down) next_mode = man_pd ? APDC_MAN_PD : APDC_AUTO_PD;
                          else if (wake_done) next_mode = APDC_ACTIVE;
            // Receivers stay on; any transmit or receive transition or force-active high wakes
            APDC_AUTO_PD: if (man_pd) next_mode = APDC_MAN_PD;
                          else if (!want_down) next_mode = APDC_WAKING; // R2
            // Shutdown released with force-active low and no transition: automatic
            APDC_MAN_PD:  if (!want_down) next_mode = APDC_WAKING;
                          else if (!man_pd) next_mode = APDC_AUTO_PD;
            // Illegal code: fall back to the safest, lowest-power state
            default:      next_mode = APDC_MAN_PD;
        endcase
    end

    // Output levels decoded from the next mode, so every pin moves with MODE
    wire next_pump_en = (next_mode == APDC_ACTIVE) || (next_mode == APDC_WAKING); // R1
    // Drivers enable only once the recovery wait is over
    wire next_tx_oe   = (next_mode == APDC_ACTIVE);     // R14
    // Inverting receivers go quiet only in manual powerdown, which keeps current
    // out of the input clamps of a switched-off peer
    wire next_rx_oe   = (next_mode != APDC_MAN_PD);     // R15
    wire next_ready   = (next_mode == APDC_ACTIVE);     // R11
    // Recovery counter runs only while staying in the wait, cleared otherwise
    wire [SHORT_W-1:0] next_wake_cnt = (next_mode == APDC_WAKING && mode == APDC_WAKING) ?
                                       wake_cnt + 1'b1 : '0;   // R11

    // Mode register, recovery counter and registered outputs
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            // Reset leaves the transceiver fully on, as with the force pins at idle
            mode                <= APDC_ACTIVE;
            wake_cnt            <= '0;
            PUMP_EN             <= 1'b1;
            TX_OE               <= 1'b1;
            RX_OE               <= 1'b1;
            MONITOR_RECEIVER_OE <= 1'b1;
            READY               <= 1'b1;
            NO_SIGNAL_N         <= 1'b1;
            MODE                <= 4'h1;
        end else begin
            mode                <= next_mode;
            wake_cnt            <= next_wake_cnt;                  // R11
            PUMP_EN             <= next_pump_en;                   // R1
            TX_OE               <= next_tx_oe;                     // R14
            RX_OE               <= next_rx_oe;                     // R15
            // Monitor receiver has no enable condition: it listens in every mode
            MONITOR_RECEIVER_OE <= 1'b1;                           // R16
            READY               <= next_ready;                     // R11
            // Pin is low once every line has stayed invalid long enough, until one stays valid long enough
            NO_SIGNAL_N         <= ~nsig.no_signal;                // R7 R9 R10 R12
            MODE                <= next_mode;
        end
    end
endmodule

// [rtl/apdc_pkg.sv]
// Package: timing constants and mode encoding for the auto powerdown control
package apdc_pkg;
    // System clock rate
    localparam longint CLK_HZ           = 10000000;
    // Timing figures as printed, in their own units
    localparam longint IDLE_TIME_S      = 30;
    localparam longint INVALID_TIME_US  = 60;
    localparam longint VALID_TIME_US    = 1;
    localparam longint WAKE_TIME_US     = 25;
    // Cycle counts derived from the rate
    localparam longint IDLE_CYCLES      = IDLE_TIME_S * CLK_HZ;
    // More than 60 us: one cycle past the rounded-up figure
    localparam longint INVALID_CYCLES   = (INVALID_TIME_US * CLK_HZ + 999999) / 1000000 + 1;
    localparam longint VALID_CYCLES     = (VALID_TIME_US * CLK_HZ + 999999) / 1000000;
    localparam longint WAKE_CYCLES      = (WAKE_TIME_US * CLK_HZ) / 1000000;
    // Counter widths
    localparam int     IDLE_W           = 32;
    localparam int     SHORT_W          = 16;
    // Power mode, one-hot
    typedef enum logic [3:0] {
        APDC_ACTIVE  = 4'h1,
        APDC_WAKING  = 4'h2,
        APDC_AUTO_PD = 4'h4,
        APDC_MAN_PD  = 4'h8
    } apdc_mode_t;
endpackage

// [rtl/apdc_if.sv]
// Interface: no-signal detector results passed to the power controller
`timescale 1ns/1ps
interface apdc_if;
    logic no_signal;   // All receiver levels invalid long enough
    modport det (output no_signal);
    modport ctl (input  no_signal);
endinterface

// [rtl/apdc_nosig.sv]
// No-signal detector: invalid-level and valid-level timers on receiver levels
`timescale 1ns/1ps
module apdc_nosig #(
    parameter int N_RX         = 4,
    parameter int INVALID_CNT  = 601,
    parameter int VALID_CNT    = 10
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Synchronised per-line valid flags
    input  wire logic [N_RX-1:0] rx_valid,
    // Result
    apdc_if.det                  res
);
    import apdc_pkg::*;

    wire any_valid = |rx_valid;          // At least one line at a valid level
    logic [SHORT_W-1:0] cnt;             // Time spent against current flag
    logic               no_sig;          // Flag state, high when nothing valid

    // Flag flips only after the opposing condition lasts its full time
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt    <= '0;
            no_sig <= 1'b0;
        end else if (no_sig == !any_valid) begin
            cnt <= '0;                   // Condition agrees with flag
        end else if (!no_sig && cnt == SHORT_W'(INVALID_CNT - 1)) begin
            no_sig <= 1'b1;              // R7
            cnt    <= '0;
        end else if (no_sig && cnt == SHORT_W'(VALID_CNT - 1)) begin
            no_sig <= 1'b0;              // R9
            cnt    <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    assign res.no_signal = no_sig;       // R10
endmodule

// [verif/apdc_host.sv]
// Host model: drives the force pins, optionally looped back from the flag
`timescale 1ns/1ps
module apdc_host (
    // Clock and commands from the bench
    input  wire logic       clk,
    input  wire logic       fa_cmd,
    input  wire logic       fs_cmd,
    input  wire logic [1:0] loop_sel,
    // Flag in, pins out
    input  wire logic       no_signal_n,
    output logic            force_active = 1'b0,
    output logic            force_shutdown = 1'b1
);
    // Pins move just after the edge; loop 1 ties flag to both, loop 2 to shutdown only
    always @(posedge clk) begin
        force_active   <= #1 (loop_sel == 2'h1) ? no_signal_n : fa_cmd;
        force_shutdown <= #1 (loop_sel != 2'h0) ? no_signal_n : fs_cmd;
    end
endmodule

// [verif/apdc_top_assertions.sv]
// Checker: port-level timing and output relations of the powerdown control
`timescale 1ns/1ps
module apdc_top_assertions
    import apdc_pkg::*;
#(
    parameter int N_TX = 5,
    parameter int N_RX = 4
) (
    // All ports of the top, observed only
    input wire logic            REF_CLK,
    input wire logic            RST,
    input wire logic            FORCE_ACTIVE_INPUT,
    input wire logic            FORCE_SHUTDOWN_INPUT,
    input wire logic [N_TX-1:0] TX_IN,
    input wire logic [N_RX-1:0] RX_IN,
    input wire logic [N_RX-1:0] RX_LEVEL_VALID,
    input wire logic            PUMP_EN,
    input wire logic            TX_OE,
    input wire logic            RX_OE,
    input wire logic            MONITOR_RECEIVER_OE,
    input wire logic            READY,
    input wire logic            NO_SIGNAL_N,
    input wire logic [3:0]      MODE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // Shutdown pin held low long enough to pass the synchroniser
    sequence s_held_off;
        !FORCE_SHUTDOWN_INPUT [*8];
    endsequence
    a_monitor_always_on: assert property (MONITOR_RECEIVER_OE)
        else $error("monitor receiver disabled");
    a_tx_hiz_down: assert property (MODE != APDC_ACTIVE |-> !TX_OE)
        else $error("transmitters driven outside active mode");
    a_rx_manual_only: assert property (RX_OE == (MODE != APDC_MAN_PD))
        else $error("receiver enable does not follow manual powerdown");
    a_pump_follows_mode: assert property (PUMP_EN == (MODE inside {APDC_ACTIVE, APDC_WAKING}))
        else $error("charge pump state does not match mode");
    a_ready_when_active: assert property (READY == (MODE == APDC_ACTIVE))
        else $error("ready does not match active mode");
    a_shutdown_forces_down: assert property (s_held_off |-> MODE == APDC_MAN_PD)
        else $error("shutdown pin low but not in manual powerdown");
    a_wake_within_time: assert property ($rose(MODE == APDC_WAKING) |-> ##[200:260] READY)
        else $error("wake did not complete in time");
    a_flag_falls_invalid: assert property (RX_LEVEL_VALID == 0 && NO_SIGNAL_N
        |-> ##[1:620] (!NO_SIGNAL_N || RX_LEVEL_VALID != 0))
        else $error("flag not low after invalid period");
    a_flag_rises_valid: assert property (RX_LEVEL_VALID != 0 && !NO_SIGNAL_N
        |-> ##[1:24] (NO_SIGNAL_N || RX_LEVEL_VALID == 0))
        else $error("flag not high after valid level");
endmodule
bind apdc_top apdc_top_assertions #(.N_TX(N_TX), .N_RX(N_RX)) u_chk (
    .REF_CLK(REF_CLK), .RST(RST), .FORCE_ACTIVE_INPUT(FORCE_ACTIVE_INPUT),
    .FORCE_SHUTDOWN_INPUT(FORCE_SHUTDOWN_INPUT), .TX_IN(TX_IN), .RX_IN(RX_IN),
    .RX_LEVEL_VALID(RX_LEVEL_VALID), .PUMP_EN(PUMP_EN), .TX_OE(TX_OE), .RX_OE(RX_OE),
    .MONITOR_RECEIVER_OE(MONITOR_RECEIVER_OE), .READY(READY), .NO_SIGNAL_N(NO_SIGNAL_N),
    .MODE(MODE));

// [verif/apdc_top_tb.sv]
// Testbench: powerdown modes, wake, flag timing and cable-detect wiring
`timescale 1ns/1ps
module apdc_top_tb;
    import apdc_pkg::*;
    logic clk = 0, rst = 1, fa = 0, fs = 1, fa_pin, fs_pin;   // Clock, reset, force
    logic [1:0] lp = 2'h0;                                     // Host loopback select
    logic [4:0] tx = 5'h00;                                    // Transmitter inputs
    logic [3:0] rx = 4'h0, rv = 4'hf, mode;                    // Receiver side, mode
    logic pump, tx_oe, rx_oe, mon, ready, flag_n;              // Observed outputs
    int failures = 0, checks_done = 0;
    always #50 clk = ~clk;
    // Idle time shortened for the run, but kept above the 250-cycle recovery wait
    apdc_top #(.IDLE_CNT(400)) u_apdc_top (.REF_CLK(clk), .RST(rst),
        .FORCE_ACTIVE_INPUT(fa_pin), .FORCE_SHUTDOWN_INPUT(fs_pin), .TX_IN(tx), .RX_IN(rx),
        .RX_LEVEL_VALID(rv), .PUMP_EN(pump), .TX_OE(tx_oe), .RX_OE(rx_oe),
        .MONITOR_RECEIVER_OE(mon), .READY(ready), .NO_SIGNAL_N(flag_n), .MODE(mode));
    apdc_host u_apdc_host (.clk(clk), .fa_cmd(fa), .fs_cmd(fs), .loop_sel(lp),
        .no_signal_n(flag_n), .force_active(fa_pin), .force_shutdown(fs_pin));
    task tick(int n); repeat (n) @(posedge clk); #1; endtask
    task chk(string what, logic [3:0] seen, logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait on mode (sel 0) or flag (sel 1); running out ends the run
    task wait_for(bit sel, logic [3:0] exp, int lim);
        for (int k = 0; k < lim && (sel ? {3'h0, flag_n} : mode) !== exp; k++) tick(1);
        chk(sel ? "flag" : "mode", sel ? {3'h0, flag_n} : mode, exp);
        if ((sel ? {3'h0, flag_n} : mode) !== exp) wrap_up();
    endtask
    task t_idle_wake;
        tick(350); chk("mode", mode, APDC_ACTIVE);
        wait_for(0, APDC_AUTO_PD, 100);
        chk("outs", {pump, tx_oe, rx_oe, mon}, 4'h3);
        tx[3] = ~tx[3]; wait_for(0, APDC_WAKING, 20);
        chk("outs", {pump, tx_oe, ready, rx_oe}, 4'h9);
        wait_for(0, APDC_ACTIVE, 300);
        chk("outs", {pump, tx_oe, ready, rx_oe}, 4'hf);
    endtask
    task t_force;
        fa = 1; tick(500); chk("mode", mode, APDC_ACTIVE);
        fa = 0; tick(350); chk("mode", mode, APDC_ACTIVE);
        wait_for(0, APDC_AUTO_PD, 100);
        tick(300); chk("mode", mode, APDC_AUTO_PD);
        fa = 1; wait_for(0, APDC_WAKING, 20);
        wait_for(0, APDC_ACTIVE, 300);
    endtask
    task t_manual;
        fs = 0; wait_for(0, APDC_MAN_PD, 20);
        chk("outs", {pump, tx_oe, rx_oe, mon}, 4'h1);
        fa = 0; rx[0] = ~rx[0]; tick(50); chk("mode", mode, APDC_MAN_PD);
        fs = 1; wait_for(0, APDC_AUTO_PD, 400);
        rx[1] = ~rx[1]; wait_for(0, APDC_WAKING, 20);
        wait_for(0, APDC_ACTIVE, 300);
    endtask
    task t_flag;
        fa = 1; fs = 0; wait_for(0, APDC_MAN_PD, 20);
        rv = 4'h0; tick(580); chk("flag", {3'h0, flag_n}, 4'h1);
        wait_for(1, 4'h0, 40);
        chk("mode", mode, APDC_MAN_PD);
        rv = 4'h4; wait_for(1, 4'h1, 25);
        fs = 1; wait_for(0, APDC_ACTIVE, 300);
        rv = 4'h0; wait_for(1, 4'h0, 640);
        chk("mode", mode, APDC_ACTIVE);
        rv = 4'hf; wait_for(1, 4'h1, 25);
    endtask
    task t_cable;
        lp = 2'h1; rv = 4'h0; wait_for(0, APDC_MAN_PD, 660);
        rv = 4'hf; wait_for(0, APDC_ACTIVE, 300);
        fa = 0; lp = 2'h2; rv = 4'h0; wait_for(0, APDC_MAN_PD, 660);
        rv = 4'hf; wait_for(0, APDC_AUTO_PD, 400);
        tx[0] = ~tx[0]; wait_for(0, APDC_WAKING, 20);
    endtask
    task wrap_up;
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Main sequence: reset for two cycles, then each scenario in turn
    initial begin
        tick(2);
        rst = 0;
        t_idle_wake();
        t_force();
        t_manual();
        t_flag();
        t_cable();
        wrap_up();
    end
endmodule
